/* rtl/sa_pkg.sv */
// constants shared by the security area block and its buffer
package sa_pkg;
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR  = 8'h05;
  localparam logic [7:0] OP_PROG  = 8'h9B;
  localparam logic [7:0] OP_READ  = 8'h77;
  localparam logic [7:0] ERASED   = 8'hFF;
  localparam int         USER_N   = 64;
  localparam int         AREA_N   = 128;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] ADDR_END = 3'h2; // index of third address byte
  localparam logic [2:0] DUMY_END = 3'h1; // index of second dummy byte
  localparam int         ST_BUSY  = 0;
  localparam int         ST_WEL   = 1;
  localparam int         FIFO_W   = 14;   // position and data byte
  localparam int         FIFO_D   = 8;
  localparam int         PROG_TIME_US = 1000;
  localparam int         CLK_MHZ  = 25;
  localparam int         PROG_CYC = PROG_TIME_US * CLK_MHZ;
  typedef enum logic [2:0] {S_OPC, S_ADDR, S_DUMY, S_RDAT, S_WDAT, S_STAT, S_IGN} sa_st_t;
  typedef enum logic [1:0] {P_IDLE, P_DRAIN, P_PROG} sa_ph_t;
endpackage

/* rtl/sa_fifo.sv */
// small fifo carrying program bytes toward the buffer
`timescale 1ns/10ps
module sa_fifo #(
  parameter int W = 14,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_reg [D];
  logic [AW:0]  wp_reg, wp_next, rp_reg, rp_next;
  logic         push, pop;
  // =====================
  // pointers
  always_comb begin
    push     = in_valid && in_ready;
    pop      = out_valid && out_ready;
    wp_next  = push ? wp_reg + 1'b1 : wp_reg;
    rp_next  = pop ? rp_reg + 1'b1 : rp_reg;
    in_ready = !((wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]));
    out_valid = wp_reg != rp_reg;
    out_data = mem_reg[rp_reg[AW-1:0]];
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end
  // storage needs no reset, the pointers guard it
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wp_reg[AW-1:0]] <= in_data;
    end
  end
endmodule // sa_fifo

/* rtl/sa_otp.sv */
// one-time-programmable security area behind a serial command port
`timescale 1ns/10ps
module sa_otp #(
  parameter int          PROG_CYCLES = sa_pkg::PROG_CYC,
  parameter logic [511:0] FACTORY_ID = {64{8'h5A}} // arbitrary value
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic mosi,
  input  wire logic nv_erase,
  output logic      so,
  output logic      so_oe,
  output logic      busy_flag,
  output logic      write_enable_latch
);
  sa_pkg::sa_st_t st_reg, st_next;
  sa_pkg::sa_ph_t ph_reg, ph_next;
  logic       sck_reg, sck_next, csn_reg, csn_next;
  logic [2:0] bit_reg, bit_next, byt_reg, byt_next;
  logic [7:0] sh_reg, sh_next, opc_reg, opc_next, ob_reg, ob_next;
  logic [6:0] adr_reg, adr_next;
  logic       got_reg, got_next, so_reg, so_next, oe_reg, oe_next;
  logic       wel_reg, wel_next, bsy_reg, bsy_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [7:0] mem_reg [sa_pkg::USER_N];
  logic [7:0] buf_reg [sa_pkg::USER_N];
  logic [sa_pkg::USER_N-1:0] vld_reg;
  logic       used_reg;
  logic       rise, fall, desel, bdone, clr_buf, push, start_p, do_wr;
  logic [7:0] b;
  logic [13:0] f_data;
  logic       f_in_rdy, f_out_vld, f_out_rdy;

  // byte at any area position, factory half from the constant
  function automatic logic [7:0] rd_area(input logic [6:0] i);
    if (i < 7'(sa_pkg::USER_N)) return mem_reg[i[5:0]];
    return FACTORY_ID[8*i[5:0] +: 8];
  endfunction

  function automatic logic [7:0] status(input logic w, input logic y);
    logic [7:0] s;
    s = 8'h00;
    s[sa_pkg::ST_WEL]  = w;
    s[sa_pkg::ST_BUSY] = y;
    return s;
  endfunction

  // =====================
  // serial command engine
  // pins are synchronous to clk, so edges come from one delayed copy
  always_comb begin
    sck_next = sck;
    csn_next = cs_n;
    rise  = !cs_n && sck && !sck_reg;
    fall  = !cs_n && !sck && sck_reg;
    desel = cs_n && !csn_reg;
    bdone = rise && bit_reg == sa_pkg::LAST_BIT;
    b     = {sh_reg[6:0], mosi};
    st_next = st_reg; ph_next = ph_reg; bit_next = bit_reg; byt_next = byt_reg;
    sh_next = sh_reg; opc_next = opc_reg; ob_next = ob_reg; adr_next = adr_reg;
    got_next = got_reg; so_next = so_reg; oe_next = oe_reg;
    wel_next = wel_reg; bsy_next = bsy_reg; cnt_next = cnt_reg;
    clr_buf = 1'b0; push = 1'b0; start_p = 1'b0; do_wr = 1'b0;
    if (rise) begin
      sh_next  = b;
      bit_next = bit_reg + 3'h1;
    end
    if (bdone) begin
      byt_next = byt_reg + 3'h1;
      case (st_reg)
        sa_pkg::S_OPC: begin
          opc_next = b;
          byt_next = 3'h0;
          got_next = 1'b0;
          if (b == sa_pkg::OP_RDSR) begin
            st_next = sa_pkg::S_STAT;
            ob_next = status(wel_reg, bsy_reg);
          end else if (bsy_reg) begin
            st_next = sa_pkg::S_IGN;  // nothing but a status read runs beside a program
          end else if (b == sa_pkg::OP_READ) begin
            st_next = sa_pkg::S_ADDR;
          end else if (b == sa_pkg::OP_PROG) begin
            st_next = sa_pkg::S_ADDR;
            clr_buf = 1'b1;
          end else begin
            st_next = sa_pkg::S_IGN;
          end
        end
        sa_pkg::S_ADDR: begin
          adr_next = b[6:0];
          if (byt_reg == sa_pkg::ADDR_END) begin
            byt_next = 3'h0;
            st_next  = (opc_reg == sa_pkg::OP_READ) ? sa_pkg::S_DUMY : sa_pkg::S_WDAT;
          end
        end
        sa_pkg::S_DUMY: begin
          if (byt_reg == sa_pkg::DUMY_END) begin
            st_next  = sa_pkg::S_RDAT;
            ob_next  = rd_area(adr_reg);
            adr_next = adr_reg + 7'h01;
          end
        end
        sa_pkg::S_RDAT: begin
          ob_next  = rd_area(adr_reg);
          adr_next = adr_reg + 7'h01;
        end
        sa_pkg::S_WDAT: begin
          push     = f_in_rdy;         // drain outruns the byte rate, so never refused
          got_next = 1'b1;
          adr_next = {1'b0, adr_reg[5:0] + 6'h01};
        end
        sa_pkg::S_STAT: ob_next = status(wel_reg, bsy_reg);
        default: ;
      endcase
    end
    // output changes on the falling edge, host samples on the rising one
    if (fall && (st_reg == sa_pkg::S_RDAT || st_reg == sa_pkg::S_STAT)) begin
      so_next = ob_reg[sa_pkg::LAST_BIT - bit_reg];
      oe_next = 1'b1;
    end
    if (cs_n) begin
      st_next  = sa_pkg::S_OPC;
      bit_next = 3'h0;
      oe_next  = 1'b0;
    end
    if (desel && !bsy_reg) begin
      if (st_reg == sa_pkg::S_IGN && bit_reg == 3'h0 && opc_reg == sa_pkg::OP_WREN) begin
        wel_next = 1'b1;
      end else if (st_reg == sa_pkg::S_IGN && bit_reg == 3'h0
                   && opc_reg == sa_pkg::OP_WRDI) begin
        wel_next = 1'b0;
      end else if (opc_reg == sa_pkg::OP_PROG && wel_reg
                   && (st_reg == sa_pkg::S_ADDR || st_reg == sa_pkg::S_WDAT)) begin
        wel_next = 1'b0;
        if (st_reg == sa_pkg::S_WDAT && got_reg && bit_reg == 3'h0 && !used_reg) begin
          ph_next  = sa_pkg::P_DRAIN;
          bsy_next = 1'b1;
        end
      end
    end
    case (ph_reg)
      sa_pkg::P_DRAIN: begin
        if (!f_out_vld) begin         // every byte must reach the buffer first
          ph_next  = sa_pkg::P_PROG;
          cnt_next = 32'h0;
          start_p  = 1'b1;
        end
      end
      sa_pkg::P_PROG: begin
        cnt_next = cnt_reg + 32'h1;
        if (cnt_reg == 32'(PROG_CYCLES - 1)) begin
          ph_next  = sa_pkg::P_IDLE;
          bsy_next = 1'b0;
          do_wr    = 1'b1;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= sa_pkg::S_OPC; ph_reg <= sa_pkg::P_IDLE;
      sck_reg <= 1'b0; csn_reg <= 1'b1;
      bit_reg <= 3'h0; byt_reg <= 3'h0; sh_reg <= 8'h00; opc_reg <= 8'h00;
      ob_reg <= 8'h00; adr_reg <= 7'h00; got_reg <= 1'b0;
      so_reg <= 1'b0; oe_reg <= 1'b0; wel_reg <= 1'b0; bsy_reg <= 1'b0;
      cnt_reg <= 32'h0;
    end else begin
      st_reg <= st_next; ph_reg <= ph_next;
      sck_reg <= sck_next; csn_reg <= csn_next;
      bit_reg <= bit_next; byt_reg <= byt_next; sh_reg <= sh_next; opc_reg <= opc_next;
      ob_reg <= ob_next; adr_reg <= adr_next; got_reg <= got_next;
      so_reg <= so_next; oe_reg <= oe_next; wel_reg <= wel_next; bsy_reg <= bsy_next;
      cnt_reg <= cnt_next;
    end
  end

  assign so                 = so_reg;
  assign so_oe              = oe_reg;
  assign busy_flag          = bsy_reg;
  assign write_enable_latch = wel_reg;

  // =====================
  // program buffer and fifo
  // buffer drain stalls while the array is written
  assign f_out_rdy = (ph_reg != sa_pkg::P_PROG);
  sa_fifo #(.W(sa_pkg::FIFO_W), .D(sa_pkg::FIFO_D)) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_data   ({adr_reg[5:0], b}),
    .in_valid  (push),
    .in_ready  (f_in_rdy),
    .out_data  (f_data),
    .out_valid (f_out_vld),
    .out_ready (f_out_rdy)
  );

  // =====================
  // nonvolatile user half, kept through nrst like real cells
  // nv_erase stands for a fresh part: all FFh and unused
  logic [7:0] mem_next [sa_pkg::USER_N];
  logic [7:0] buf_next [sa_pkg::USER_N];
  logic [sa_pkg::USER_N-1:0] vld_next;
  logic       used_next;
  always_comb begin
    mem_next = mem_reg; buf_next = buf_reg; vld_next = vld_reg; used_next = used_reg;
    if (clr_buf) begin
      vld_next = '0;
      for (int i = 0; i < sa_pkg::USER_N; i++) buf_next[i] = sa_pkg::ERASED;
    end
    if (f_out_vld && f_out_rdy) begin
      buf_next[f_data[13:8]] = f_data[7:0];
      vld_next[f_data[13:8]] = 1'b1;
    end
    if (start_p) used_next = 1'b1;
    if (do_wr) begin
      for (int i = 0; i < sa_pkg::USER_N; i++) begin
        if (vld_reg[i]) mem_next[i] = buf_reg[i];
      end
    end
    if (nv_erase) begin
      used_next = 1'b0;
      for (int i = 0; i < sa_pkg::USER_N; i++) mem_next[i] = sa_pkg::ERASED;
    end
  end
  always_ff @(posedge clk) begin
    mem_reg  <= mem_next;
    buf_reg  <= buf_next;
    vld_reg  <= vld_next;
    used_reg <= used_next;
  end
endmodule // sa_otp

/* verification/sa_otp_monitor.sv */
// checker watching the security area serial port
`timescale 1ns/10ps
module sa_otp_monitor #(
  parameter int PROG_CYCLES = 25000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic nv_erase,
  input wire logic so,
  input wire logic so_oe,
  input wire logic busy_flag,
  input wire logic write_enable_latch
);
  // ==========
  // busy length counter, a repetition that long would not unroll
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  always_comb cnt_next = busy_flag ? cnt_reg + 32'h1 : 32'h0;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) cnt_reg <= 32'h0;
    else cnt_reg <= cnt_next;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_OE_DROP: assert property ($rose(cs_n) |-> ##1 !so_oe)
    else $error("output enable held after deselect");
  AST_OE_IDLE: assert property (cs_n [*2] |-> !so_oe)
    else $error("output driven while deselected");
  AST_OE_START: assert property ($rose(so_oe) |-> !cs_n && !sck)
    else $error("output enabled outside a low clock phase");
  AST_SO_HOLD: assert property (so_oe && $past(so_oe) && $changed(so) |-> !sck)
    else $error("serial output moved while clock high");
  AST_WEL_SET: assert property ($rose(write_enable_latch) |-> cs_n)
    else $error("latch set while selected");
  AST_BUSY_START: assert property ($rose(busy_flag) |-> cs_n && !write_enable_latch)
    else $error("busy began without deselect or latch kept");
  AST_BUSY_LATCH: assert property ($rose(busy_flag) |-> $past(write_enable_latch))
    else $error("program started without latch");
  AST_BUSY_NO_WEL: assert property (busy_flag |-> !write_enable_latch)
    else $error("latch set during programming");
  AST_BUSY_MIN: assert property ($fell(busy_flag) |-> cnt_reg >= PROG_CYCLES)
    else $error("programming ended early");
  AST_BUSY_MAX: assert property (busy_flag |-> cnt_reg <= PROG_CYCLES + 10)
    else $error("programming ran too long");
  COV_PROG: cover property ($rose(busy_flag));
  COV_DONE: cover property ($fell(busy_flag));
  COV_READ: cover property ($rose(so_oe));
  COV_WEL: cover property ($rose(write_enable_latch));
endmodule // sa_otp_monitor

bind sa_otp sa_otp_monitor #(.PROG_CYCLES(PROG_CYCLES)) i_sa_otp_monitor (
  .clk(clk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .mosi(mosi), .nv_erase(nv_erase),
  .so(so), .so_oe(so_oe), .busy_flag(busy_flag), .write_enable_latch(write_enable_latch));

/* verification/sa_host.sv */
// spi host model driving the security area serial port
`timescale 1ns/10ps
module sa_host (
  input  wire logic clk,
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic so
);
  // ==========
  logic [7:0] rx;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    rx = 8'h00;
  end
  task automatic start();
    @(negedge clk);
    cs_n = 1'b0;
  endtask
  // two clk per phase so every edge is seen; rx taken before the rising edge
  task automatic shift(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      @(negedge clk);
      sck = 1'b0;
      mosi = b[i];
      repeat (2) @(negedge clk);
      rx = {rx[6:0], so};
      sck = 1'b1;
      @(negedge clk);
    end
  endtask
  task automatic stop();
    @(negedge clk);
    sck = 1'b0;
    repeat (2) @(negedge clk);
    cs_n = 1'b1;
    mosi = ~mosi; // released data line moves so stale bits never look valid
    repeat (3) @(negedge clk);
  endtask
endmodule // sa_host

/* verification/sa_otp_bench.sv */
// self-checking bench for the security area block
`timescale 1ns/10ps
module sa_otp_bench;
  // ==========
  localparam int         PROG_N = 200;
  localparam logic [7:0] FACT   = 8'h3C; // arbitrary value
  logic       clk;
  logic       nrst;
  logic       nv_erase;
  logic       sck;
  logic       cs_n;
  logic       mosi;
  logic       so;
  logic       so_oe;
  logic       so_line;
  logic       busy_flag;
  logic       write_enable_latch;
  logic [7:0] exp_mem [128];
  logic [7:0] st;
  int         error_cnt = 0;
  int         checks = 0;
  sa_otp #(.PROG_CYCLES(PROG_N), .FACTORY_ID({64{FACT}})) i_sa_otp (.clk(clk), .nrst(nrst),
    .sck(sck), .cs_n(cs_n), .mosi(mosi), .nv_erase(nv_erase), .so(so), .so_oe(so_oe),
    .busy_flag(busy_flag), .write_enable_latch(write_enable_latch));
  // released output reads as the line's pull-up level, so a missing enable shows
  assign so_line = so_oe ? so : 1'b1;
  sa_host i_sa_host (.clk(clk), .sck(sck), .cs_n(cs_n), .mosi(mosi), .so(so_line));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp1(input string what, input logic exp, input logic got);
    cmp8(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op);
    i_sa_host.start();
    i_sa_host.shift(op, 8);
    i_sa_host.stop();
  endtask
  task automatic status(output logic [7:0] s);
    i_sa_host.start();
    i_sa_host.shift(sa_pkg::OP_RDSR, 8);
    i_sa_host.shift(8'h00, 8);
    s = i_sa_host.rx;
    i_sa_host.stop();
  endtask
  // high address bytes all ones: they must not matter
  task automatic prog(input logic [7:0] lo, input int n, input int extra, input logic [7:0] b);
    i_sa_host.start();
    i_sa_host.shift(sa_pkg::OP_PROG, 8);
    repeat (2) i_sa_host.shift(8'hFF, 8);
    i_sa_host.shift(lo, 8);
    for (int i = 0; i < n; i++) i_sa_host.shift(b + 8'(i), 8);
    if (extra > 0) i_sa_host.shift(8'hC3, extra);
    i_sa_host.stop();
  endtask
  // reads n bytes, then leaves in mid-byte
  task automatic read_all(input logic [7:0] lo, input int n);
    i_sa_host.start();
    i_sa_host.shift(sa_pkg::OP_READ, 8);
    repeat (2) i_sa_host.shift(8'hFF, 8);
    i_sa_host.shift(lo, 8);
    repeat (2) i_sa_host.shift(8'h00, 8);
    for (int i = 0; i < n; i++) begin
      i_sa_host.shift(8'h00, 8);
      cmp8("area byte", exp_mem[(int'(lo[6:0]) + i) % 128], i_sa_host.rx);
    end
    i_sa_host.shift(8'h00, 3);
    i_sa_host.stop();
    cmp1("output enable", 1'b0, so_oe);
  endtask
  task automatic wait_ready();
    st = 8'h01;
    for (int k = 0; k < 40 && st[0] !== 1'b0; k++) status(st);
    cmp8("status after program", 8'h00, st);
  endtask
  // nonvolatile wipe models fresh silicon
  task automatic erase();
    @(negedge clk);
    nv_erase = 1'b1;
    repeat (2) @(negedge clk);
    nv_erase = 1'b0;
    for (int i = 0; i < 128; i++) exp_mem[i] = i < 64 ? sa_pkg::ERASED : FACT;
  endtask
  task automatic t_no_latch();
    status(st);
    cmp8("idle status", 8'h00, st);
    prog(8'h00, 1, 0, 8'h12);
    cmp1("busy without latch", 1'b0, busy_flag);
  endtask
  // missing data byte and partial data byte both abort and drop the latch;
  // the byte left at 10h by the partial one must not leak into the next program
  task automatic t_abort();
    cmd(sa_pkg::OP_WREN);
    status(st);
    cmp8("latch set", 8'h02, st);
    prog(8'h00, 0, 0, 8'h12);
    status(st);
    cmp8("after no data", 8'h00, st);
    cmd(sa_pkg::OP_WREN);
    prog(8'h10, 1, 3, 8'h12);
    status(st);
    cmp8("after partial byte", 8'h00, st);
  endtask
  // start at 3Eh wraps; a second program on the used half is refused
  task automatic t_program();
    cmd(sa_pkg::OP_WREN);
    prog(8'hFE, 3, 0, 8'hA1);
    cmp1("busy after deselect", 1'b1, busy_flag);
    status(st);
    cmp8("status while busy", 8'h01, st);
    wait_ready();
    for (int i = 0; i < 3; i++) exp_mem[(62 + i) % 64] = 8'hA1 + 8'(i);
    cmd(sa_pkg::OP_WREN);
    prog(8'h00, 1, 0, 8'h00);
    cmp1("busy on used half", 1'b0, busy_flag);
    status(st);
    cmp8("latch after refusal", 8'h00, st);
    read_all(8'h80, 129);
  endtask
  // more than 64 bytes on a fresh half: the last 64 survive
  task automatic t_overrun();
    erase();
    cmd(sa_pkg::OP_WREN);
    prog(8'h40, 66, 0, 8'h10);
    wait_ready();
    for (int i = 0; i < 66; i++) exp_mem[i % 64] = 8'h10 + 8'(i);
    read_all(8'h00, 64);
  endtask
  // power lost mid-program: the half counts as used from then on
  task automatic t_power_loss();
    erase();
    cmd(sa_pkg::OP_WREN);
    prog(8'h00, 2, 0, 8'h66);
    repeat (5) @(negedge clk);
    cmp1("busy before power loss", 1'b1, busy_flag);
    nrst = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    cmp1("latch pin after reset", 1'b0, write_enable_latch);
    cmp1("busy after reset", 1'b0, busy_flag);
    cmd(sa_pkg::OP_WREN);
    cmp1("latch pin", 1'b1, write_enable_latch);
    prog(8'h00, 1, 0, 8'h77);
    cmp1("busy on half cut by power loss", 1'b0, busy_flag);
    status(st);
    cmp8("latch after power loss refusal", 8'h00, st);
  endtask
  initial begin
    nrst = 1'b0;
    nv_erase = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    erase();
    t_no_latch();
    t_abort();
    t_program();
    t_overrun();
    t_power_loss();
    print_verdict();
  end
  // whole run is near 11k clk, so over five times that means a hang
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
endmodule // sa_otp_bench
